// [rtl/mps_pkg.sv]
// package of constants and types for the motion program sequencer
package mps_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_NS         = 1_000_000;
  localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_COUNT    = 120;
  localparam int PROG_COUNT    = 8;
  localparam int VAL_W         = 24;
  localparam int OP_LSB        = 24;
  localparam logic [7:0]  ADDR_START_BASE = 8'h80;
  localparam logic [7:0]  ADDR_ON_TIME    = 8'h88;
  localparam logic [7:0]  ADDR_SCURVE_DEF = 8'h89;
  localparam logic [7:0]  ADDR_STATUS     = 8'h8A;
  localparam int STAT_RUN_BIT  = 0;
  localparam int STAT_ERR_BIT  = 1;
  localparam int STAT_PC_LSB   = 8;
  localparam logic signed [23:0] OUT_INDEX = 24'sh000001;
  localparam logic [15:0] ON_TIME_RST = 16'h0000;
  localparam logic [7:0]  SCURVE_RST  = 8'h00;

  typedef enum logic [4:0] {
    OP_END     = 5'b00000, OP_SPEED  = 5'b00001, OP_ACCEL   = 5'b00010,
    OP_DECEL   = 5'b00011, OP_ACCDEC = 5'b00100, OP_SCURVE  = 5'b00101,
    OP_MOVABS  = 5'b00110, OP_MOVABSC = 5'b00111, OP_MOVREL = 5'b01000,
    OP_MOVRELC = 5'b01001, OP_WAITIN = 5'b01010, OP_OUTSET  = 5'b01011,
    OP_OUTCLR  = 5'b01100, OP_WPABS  = 5'b01101, OP_WPREL   = 5'b01110,
    OP_HALT    = 5'b01111, OP_TALLY  = 5'b10000, OP_LOOPB   = 5'b10001,
    OP_LOOPE   = 5'b10010, OP_DWELL  = 5'b10011, OP_HOME    = 5'b10100,
    OP_REPEAT  = 5'b10101
  } mps_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_WAIT = 2'b10, ST_ERR = 2'b11
  } mps_state_t;

  typedef struct packed {
    mps_op_t            op;
    logic signed [23:0] val;
  } mps_step_t;

  typedef struct packed {
    logic               chained;
    logic               relative;
    logic signed [23:0] target;
    logic [23:0]        speed;
    logic [15:0]        accel;
    logic [15:0]        decel;
    logic [7:0]         scurve;
  } mps_motion_t;
endpackage : mps_pkg

// [rtl/mps_sequencer.sv]
// stored positioning program step sequencer
//
// The implementer's own choices: the placing of the registers and strobed register access.
module mps_sequencer #(
  parameter int MS_CYCLES = mps_pkg::MS_CYCLES
) (
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire logic [7:0]         busAddr,
  input  wire logic [31:0]        busWdata,
  input  wire logic               busWr,
  input  wire logic               busRd,
  output logic [31:0]             busRdata,
  input  wire logic [2:0]         progSel,
  input  wire logic               progStart,
  input  wire logic               progIn1,
  input  wire logic               motionBusy,
  input  wire logic signed [23:0] curPos,
  input  wire logic               interruptIn,
  input  wire logic               homeDone,
  input  wire logic signed [23:0] pulseCount,
  output logic                    syncStrobe,
  output logic                    progOut1,
  output mps_pkg::mps_motion_t    motionCmd,
  output logic                    motionGo,
  output logic                    homeGo,
  output logic                    haltGo,
  output logic                    tallyClear,
  output logic                    running,
  output logic                    progError
);
  mps_pkg::mps_step_t   prog_q [mps_pkg::STEP_COUNT];
  logic [6:0]           startTab_q [mps_pkg::PROG_COUNT];
  logic [15:0]          onTime_q;
  logic [7:0]           scurveDef_q;
  mps_pkg::mps_state_t  state_q;
  logic [6:0]           pc_q;
  logic [6:0]           progBase_q;
  mps_pkg::mps_op_t     prevOp_q;
  logic [14:0]          tickCnt_q;
  logic [15:0]          timerMs_q;
  logic [23:0]          spd_q;
  logic [15:0]          acc_q;
  logic [15:0]          dec_q;
  logic [7:0]           scv_q;
  logic                 scurveOn_q;
  logic signed [24:0]   endPos_q;
  logic signed [24:0]   relStart_q;
  logic signed [24:0]   capPos_q;
  logic                 relValid_q;
  logic                 absUp_q;
  logic                 haltArmed_q;
  logic [6:0]           loopStart_q;
  logic [13:0]          loopLeft_q;
  logic                 loopForever_q;
  logic [13:0]          repLeft_q;
  logic                 repForever_q;
  logic                 firstPass_q;
  mps_pkg::mps_step_t   curStep;
  logic signed [24:0]   posW;
  logic signed [24:0]   valW;
  logic signed [24:0]   newEnd;
  logic                 msTick;
  logic                 absReached;
  logic                 relReached;
  logic                 haltSkip;
  logic                 haltDone;
  logic                 tallyOver;
  logic                 idxOk;

  function automatic logic [24:0] mag(input logic signed [24:0] x);
    mag = x[24] ? 25'(-x) : 25'(x);
  endfunction : mag

  ////////////////////////////////////////////////////////////////////////////
  // step decode and position compares
  assign curStep    = (pc_q < 7'(mps_pkg::STEP_COUNT)) ? prog_q[pc_q] : '0;
  assign posW       = 25'(curPos);
  assign valW       = 25'(curStep.val);
  assign idxOk      = (curStep.val == mps_pkg::OUT_INDEX);
  assign newEnd     = (curStep.op == mps_pkg::OP_MOVREL)  ? 25'(posW + valW) :
                      (curStep.op == mps_pkg::OP_MOVRELC) ? 25'(endPos_q + valW) : valW;
  assign absReached = absUp_q ? (posW >= valW) : (posW <= valW);
  assign relReached = mag(25'(posW - relStart_q)) >= mag(valW);
  assign haltSkip   = mag(25'(endPos_q - posW)) < mag(valW);
  assign haltDone   = mag(25'(posW - capPos_q)) >= mag(valW);
  assign tallyOver  = 25'(pulseCount) > valW;
  assign msTick     = (tickCnt_q == 15'(MS_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////////
  // program store and configuration writes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < mps_pkg::STEP_COUNT; i++) begin
        prog_q[i] <= '0;
      end
      for (int i = 0; i < mps_pkg::PROG_COUNT; i++) begin
        startTab_q[i] <= 7'h00;
      end
      onTime_q    <= mps_pkg::ON_TIME_RST;
      scurveDef_q <= mps_pkg::SCURVE_RST;
    end else if (busWr) begin
      if (busAddr < 8'(mps_pkg::STEP_COUNT)) begin
        prog_q[busAddr[6:0]] <= mps_pkg::mps_step_t'(busWdata[mps_pkg::OP_LSB + 4:0]);
      end else if (busAddr[7:3] == mps_pkg::ADDR_START_BASE[7:3]) begin
        startTab_q[busAddr[2:0]] <= busWdata[6:0];
      end else if (busAddr == mps_pkg::ADDR_ON_TIME) begin
        onTime_q <= busWdata[15:0];
      end else if (busAddr == mps_pkg::ADDR_SCURVE_DEF) begin
        scurveDef_q <= busWdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads, data stand one cycle later
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busRdata <= 32'h0000_0000;
    end else begin
      busRdata <= 32'h0000_0000;
      if (busRd) begin
        if (busAddr < 8'(mps_pkg::STEP_COUNT)) begin
          busRdata <= 32'(prog_q[busAddr[6:0]]);
        end else if (busAddr[7:3] == mps_pkg::ADDR_START_BASE[7:3]) begin
          busRdata <= 32'(startTab_q[busAddr[2:0]]);
        end else if (busAddr == mps_pkg::ADDR_ON_TIME) begin
          busRdata <= 32'(onTime_q);
        end else if (busAddr == mps_pkg::ADDR_SCURVE_DEF) begin
          busRdata <= 32'(scurveDef_q);
        end else if (busAddr == mps_pkg::ADDR_STATUS) begin
          busRdata[mps_pkg::STAT_RUN_BIT]       <= running;
          busRdata[mps_pkg::STAT_ERR_BIT]       <= progError;
          busRdata[mps_pkg::STAT_PC_LSB +: 7]   <= pc_q;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // millisecond prescaler, restarted on every step entry
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_q <= 15'h0000;
    end else if (state_q != mps_pkg::ST_WAIT || msTick) begin
      tickCnt_q <= 15'h0000;
    end else begin
      tickCnt_q <= tickCnt_q + 15'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prevOp_q <= mps_pkg::OP_END;
    end else if (state_q == mps_pkg::ST_RUN) begin
      prevOp_q <= curStep.op;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // step sequencer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q       <= mps_pkg::ST_IDLE;
      pc_q          <= 7'h00;
      progBase_q    <= 7'h00;
      timerMs_q     <= 16'h0000;
      spd_q         <= 24'h000000;
      acc_q         <= 16'h0000;
      dec_q         <= 16'h0000;
      scv_q         <= 8'h00;
      scurveOn_q    <= 1'b0;
      endPos_q      <= 25'sh0000000;
      relStart_q    <= 25'sh0000000;
      capPos_q      <= 25'sh0000000;
      relValid_q    <= 1'b0;
      absUp_q       <= 1'b0;
      haltArmed_q   <= 1'b0;
      loopStart_q   <= 7'h00;
      loopLeft_q    <= 14'h0000;
      loopForever_q <= 1'b0;
      repLeft_q     <= 14'h0001;
      repForever_q  <= 1'b0;
      firstPass_q   <= 1'b0;
      syncStrobe    <= 1'b0;
      progOut1      <= 1'b0;
      motionCmd     <= '0;
      motionGo      <= 1'b0;
      homeGo        <= 1'b0;
      haltGo        <= 1'b0;
      tallyClear    <= 1'b0;
      running       <= 1'b0;
      progError     <= 1'b0;
    end else begin
      syncStrobe <= 1'b0;
      motionGo   <= 1'b0;
      homeGo     <= 1'b0;
      haltGo     <= 1'b0;
      tallyClear <= 1'b0;
      case (state_q)
        mps_pkg::ST_IDLE, mps_pkg::ST_ERR: begin
          if (progStart) begin
            pc_q         <= startTab_q[progSel];
            progBase_q   <= startTab_q[progSel];
            repLeft_q    <= 14'h0001;
            repForever_q <= 1'b0;
            firstPass_q  <= 1'b1;
            relValid_q   <= 1'b0;
            scurveOn_q   <= 1'b0;
            haltArmed_q  <= 1'b0;
            progError    <= 1'b0;
            running      <= 1'b1;
            state_q      <= mps_pkg::ST_RUN;
          end
        end
        mps_pkg::ST_RUN: begin
          pc_q <= pc_q + 7'h01;
          case (curStep.op)
            mps_pkg::OP_SPEED:  spd_q <= curStep.val;
            mps_pkg::OP_ACCEL:  acc_q <= curStep.val[15:0];
            mps_pkg::OP_DECEL:  dec_q <= curStep.val[15:0];
            mps_pkg::OP_ACCDEC: begin
              acc_q <= curStep.val[15:0];
              dec_q <= curStep.val[15:0];
            end
            mps_pkg::OP_SCURVE: begin
              scv_q      <= curStep.val[7:0];
              scurveOn_q <= 1'b1;
            end
            mps_pkg::OP_MOVABS, mps_pkg::OP_MOVREL,
            mps_pkg::OP_MOVABSC, mps_pkg::OP_MOVRELC: begin
              if (motionBusy && (curStep.op == mps_pkg::OP_MOVABS ||
                                 curStep.op == mps_pkg::OP_MOVREL)) begin
                pc_q <= pc_q;
              end else begin
                motionGo           <= 1'b1;
                motionCmd.target   <= curStep.val;
                motionCmd.relative <= curStep.op == mps_pkg::OP_MOVREL ||
                                      curStep.op == mps_pkg::OP_MOVRELC;
                motionCmd.chained  <= curStep.op == mps_pkg::OP_MOVABSC ||
                                      curStep.op == mps_pkg::OP_MOVRELC;
                motionCmd.speed    <= spd_q;
                if (curStep.op == mps_pkg::OP_MOVABS || curStep.op == mps_pkg::OP_MOVREL) begin
                  motionCmd.accel  <= acc_q;
                  motionCmd.decel  <= dec_q;
                  motionCmd.scurve <= scurveOn_q ? scv_q : scurveDef_q;
                end
                endPos_q <= newEnd;
                absUp_q  <= newEnd >= posW;
                relValid_q <= curStep.op == mps_pkg::OP_MOVREL ||
                              curStep.op == mps_pkg::OP_MOVRELC;
                if (curStep.op == mps_pkg::OP_MOVREL) begin
                  relStart_q <= posW;
                end
              end
            end
            mps_pkg::OP_WAITIN: begin
              if (!idxOk) begin
                state_q <= mps_pkg::ST_ERR;
              end else begin
                syncStrobe <= 1'b1;
                pc_q       <= pc_q;
                state_q    <= mps_pkg::ST_WAIT;
              end
            end
            mps_pkg::OP_OUTSET: begin
              if (!idxOk) begin
                state_q <= mps_pkg::ST_ERR;
              end else begin
                progOut1 <= 1'b1;
                if (onTime_q != 16'h0000) begin
                  timerMs_q <= onTime_q;
                  pc_q      <= pc_q;
                  state_q   <= mps_pkg::ST_WAIT;
                end
              end
            end
            mps_pkg::OP_OUTCLR: begin
              if (!idxOk) begin
                state_q <= mps_pkg::ST_ERR;
              end else begin
                progOut1 <= 1'b0;
              end
            end
            mps_pkg::OP_WPREL: begin
              if (!relValid_q) begin
                state_q <= mps_pkg::ST_ERR;
              end else begin
                pc_q    <= pc_q;
                state_q <= mps_pkg::ST_WAIT;
              end
            end
            mps_pkg::OP_HALT: begin
              if (prevOp_q != mps_pkg::OP_WAITIN) begin
                state_q <= mps_pkg::ST_ERR;
              end else if (!haltSkip) begin
                pc_q    <= pc_q;
                state_q <= mps_pkg::ST_WAIT;
              end
            end
            mps_pkg::OP_TALLY: begin
              if (curStep.val == 24'sh000000) begin
                tallyClear <= 1'b1;
              end else begin
                pc_q    <= pc_q;
                state_q <= mps_pkg::ST_WAIT;
              end
            end
            mps_pkg::OP_WPABS, mps_pkg::OP_HOME: begin
              homeGo  <= curStep.op == mps_pkg::OP_HOME;
              pc_q    <= pc_q;
              state_q <= mps_pkg::ST_WAIT;
            end
            mps_pkg::OP_DWELL: begin
              timerMs_q <= curStep.val[15:0];
              pc_q      <= pc_q;
              state_q   <= mps_pkg::ST_WAIT;
            end
            mps_pkg::OP_LOOPB: begin
              loopStart_q   <= pc_q + 7'h01;
              loopLeft_q    <= curStep.val[13:0];
              loopForever_q <= curStep.val == 24'sh000000;
            end
            mps_pkg::OP_LOOPE: begin
              if (loopForever_q || loopLeft_q > 14'h0001) begin
                pc_q       <= loopStart_q;
                loopLeft_q <= loopForever_q ? loopLeft_q : loopLeft_q - 14'h0001;
              end
            end
            mps_pkg::OP_REPEAT: begin
              if (firstPass_q && pc_q == progBase_q) begin
                repLeft_q    <= curStep.val[13:0];
                repForever_q <= curStep.val == 24'sh000000;
              end
            end
            mps_pkg::OP_END: begin
              scurveOn_q  <= 1'b0;
              firstPass_q <= 1'b0;
              if (repForever_q || repLeft_q > 14'h0001) begin
                pc_q      <= progBase_q;
                repLeft_q <= repForever_q ? repLeft_q : repLeft_q - 14'h0001;
              end else begin
                progOut1 <= 1'b0;
                running  <= 1'b0;
                pc_q     <= pc_q;
                state_q  <= mps_pkg::ST_IDLE;
              end
            end
            default: ;
          endcase
        end
        mps_pkg::ST_WAIT: begin
          // waits below never look at motionBusy
          case (curStep.op)
            mps_pkg::OP_WAITIN: begin
              if (progIn1) begin
                pc_q    <= pc_q + 7'h01;
                state_q <= mps_pkg::ST_RUN;
              end
            end
            mps_pkg::OP_OUTSET, mps_pkg::OP_DWELL: begin
              if (timerMs_q == 16'h0000) begin
                if (curStep.op == mps_pkg::OP_OUTSET) begin
                  progOut1 <= 1'b0;
                end
                pc_q    <= pc_q + 7'h01;
                state_q <= mps_pkg::ST_RUN;
              end else if (msTick) begin
                timerMs_q <= timerMs_q - 16'h0001;
              end
            end
            mps_pkg::OP_HALT: begin
              if (!haltArmed_q) begin
                if (interruptIn) begin
                  capPos_q    <= posW;
                  haltArmed_q <= 1'b1;
                end
              end else if (haltDone) begin
                haltGo      <= 1'b1;
                haltArmed_q <= 1'b0;
                pc_q        <= pc_q + 7'h01;
                state_q     <= mps_pkg::ST_RUN;
              end
            end
            default: begin
              if ((curStep.op == mps_pkg::OP_WPABS && absReached) ||
                  (curStep.op == mps_pkg::OP_WPREL && relReached) ||
                  (curStep.op == mps_pkg::OP_TALLY && tallyOver) ||
                  (curStep.op == mps_pkg::OP_HOME && homeDone)) begin
                pc_q    <= pc_q + 7'h01;
                state_q <= mps_pkg::ST_RUN;
              end
            end
          endcase
        end
        default: state_q <= mps_pkg::ST_IDLE;
      endcase
      if (state_q == mps_pkg::ST_RUN && curStep.op inside {mps_pkg::OP_WAITIN,
          mps_pkg::OP_OUTSET, mps_pkg::OP_OUTCLR} && !idxOk ||
          state_q == mps_pkg::ST_RUN && curStep.op == mps_pkg::OP_WPREL && !relValid_q ||
          state_q == mps_pkg::ST_RUN && curStep.op == mps_pkg::OP_HALT &&
          prevOp_q != mps_pkg::OP_WAITIN) begin
        progError <= 1'b1;
        progOut1  <= 1'b0;
        running   <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_SYNC_PULSE: assert property (
    state_q == mps_pkg::ST_RUN && curStep.op == mps_pkg::OP_WAITIN && idxOk
    |=> syncStrobe && state_q == mps_pkg::ST_WAIT)
    else $error("sync strobe missing on wait-input step");
  AST_WAIT_HOLD: assert property (
    state_q == mps_pkg::ST_WAIT && curStep.op == mps_pkg::OP_WAITIN && !progIn1
    |=> $stable(pc_q))
    else $error("wait-input advanced without input");
  AST_OUT_SET: assert property (
    state_q == mps_pkg::ST_RUN && curStep.op == mps_pkg::OP_OUTSET && idxOk
    |=> progOut1)
    else $error("output not set");
  AST_OUT_CLR: assert property (
    state_q == mps_pkg::ST_RUN && curStep.op == mps_pkg::OP_OUTCLR && idxOk
    |=> !progOut1)
    else $error("output not cleared");
  AST_PROG_END: assert property (
    state_q == mps_pkg::ST_RUN && curStep.op == mps_pkg::OP_END && !repForever_q &&
    repLeft_q <= 14'h0001 |=> !progOut1 && !running && state_q == mps_pkg::ST_IDLE)
    else $error("program end left output or run flag");
  AST_WPREL_ERR: assert property (
    state_q == mps_pkg::ST_RUN && curStep.op == mps_pkg::OP_WPREL && !relValid_q
    |=> progError && state_q == mps_pkg::ST_ERR)
    else $error("relative waypoint error not raised");
  AST_HALT_ERR: assert property (
    state_q == mps_pkg::ST_RUN && curStep.op == mps_pkg::OP_HALT &&
    prevOp_q != mps_pkg::OP_WAITIN |=> progError)
    else $error("halt after wrong step not flagged");
  AST_TALLY_CLR: assert property (
    state_q == mps_pkg::ST_RUN && curStep.op == mps_pkg::OP_TALLY &&
    curStep.val == 24'sh000000 |=> tallyClear && $past(pc_q) + 7'h01 == pc_q)
    else $error("tally zero did not clear and advance");
  AST_DWELL_HOLD: assert property (
    state_q == mps_pkg::ST_WAIT && curStep.op == mps_pkg::OP_DWELL &&
    timerMs_q != 16'h0000 |=> $stable(pc_q))
    else $error("dwell advanced early");
endmodule : mps_sequencer

// [dv/mps_far_side.sv]
// far-side model: motion generator, home return and pulse counter
module mps_far_side (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire mps_pkg::mps_motion_t motionCmd,
  input  wire logic                 motionGo,
  input  wire logic                 homeGo,
  input  wire logic                 tallyClear,
  output logic                      motionBusy,
  output logic signed [23:0]        curPos,
  output logic                      homeDone,
  output logic signed [23:0]        pulseCount
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] busyCnt;
  assign motionBusy = busyCnt != 4'h0;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {busyCnt, homeDone, curPos, pulseCount} <= '0;
    end else begin
      // each move keeps the generator busy for six cycles
      busyCnt <= motionGo ? 4'h6 : busyCnt - {3'h0, motionBusy};
      homeDone <= homeGo;
      if (motionGo) curPos <= motionCmd.relative ? curPos + motionCmd.target : motionCmd.target;
      pulseCount <= tallyClear ? 24'sh000000 : pulseCount + 24'sh000001;
    end
  end
endmodule : mps_far_side

// [dv/testbench.sv]
// self-checking bench for the motion program sequencer
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MSC = 4;
  logic clk_sys = 1'b0, rst_n = 1'b0, busWr = 1'b0, busRd = 1'b0, progStart = 1'b0;
  logic progIn1 = 1'b0, interruptIn = 1'b0, sawHome = 1'b0, sawHalt = 1'b0;
  logic motionBusy, homeDone, syncStrobe, progOut1, motionGo, homeGo, haltGo, tallyClear;
  logic running, progError;
  logic [7:0] busAddr = 8'h00;
  logic [2:0] progSel = 3'h0;
  logic [23:0] dw;
  logic [31:0] busWdata = 32'h00000000, busRdata, rd, rng = 32'h000096DB;
  logic signed [23:0] curPos, pulseCount;
  mps_pkg::mps_motion_t motionCmd, lastCmd = '0;
  int errors = 0, total_checks = 0, n, clrCnt = 0;
  wire [3:0] mon = {running, progError, progOut1, syncStrobe};
  always #20 clk_sys = ~clk_sys;
  mps_sequencer #(.MS_CYCLES(MSC)) dut (.clk_sys, .rst_n, .busAddr, .busWdata, .busWr, .busRd,
    .busRdata, .progSel, .progStart, .progIn1, .motionBusy, .curPos, .interruptIn, .homeDone,
    .pulseCount, .syncStrobe, .progOut1, .motionCmd, .motionGo, .homeGo, .haltGo, .tallyClear,
    .running, .progError);
  mps_far_side far (.clk_sys, .rst_n, .motionCmd, .motionGo, .homeGo, .tallyClear, .motionBusy,
    .curPos, .homeDone, .pulseCount);
  always @(posedge clk_sys) begin
    if (homeGo) sawHome <= 1'b1;
    if (haltGo) sawHalt <= 1'b1;
    if (tallyClear) clrCnt <= clrCnt + 1;
    if (motionGo) lastCmd <= motionCmd;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [31:0] st(input mps_pkg::mps_op_t op, input logic [23:0] v);
    return {3'h0, op, v};
  endfunction : st
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %0h, seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    busAddr <= a;
    busWdata <= d;
    busWr <= 1'b1;
    @(posedge clk_sys);
    busWr <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge clk_sys);
    busAddr <= a;
    busRd <= 1'b1;
    @(posedge clk_sys);
    busRd <= 1'b0;
    @(negedge clk_sys);
    rd = busRdata;
  endtask : rdr
  task automatic start(input logic [2:0] s);
    @(posedge clk_sys);
    progSel <= s;
    progStart <= 1'b1;
    @(posedge clk_sys);
    progStart <= 1'b0;
  endtask : start
  // bounded wait for a monitored output to reach a level
  task automatic wt(input int i, input logic v, input int lim);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (mon[i] !== v && n < lim);
  endtask : wt
  task automatic conclude;
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    rng = xs(rng);
    dw = {22'h0, rng[17:16]} + 24'h000001;
    wr(mps_pkg::ADDR_SCURVE_DEF, {24'h0, rng[7:0]});
    rdr(mps_pkg::ADDR_SCURVE_DEF);
    chk("scurve default", rd, {24'h0, rng[7:0]});
    rdr(8'hFF);
    chk("unmapped read", rd, 32'h00000000);
    wr(8'h00, st(mps_pkg::OP_WAITIN, 24'h000001));
    wr(8'h01, st(mps_pkg::OP_OUTSET, 24'h000001));
    wr(8'h02, st(mps_pkg::OP_DWELL, dw));
    wr(8'h03, st(mps_pkg::OP_OUTCLR, 24'h000001));
    wr(8'h04, st(mps_pkg::OP_HOME, 24'h000000));
    wr(8'h05, st(mps_pkg::OP_TALLY, 24'h000000));
    wr(8'h06, st(mps_pkg::OP_TALLY, 24'h000003));
    wr(8'h07, st(mps_pkg::OP_SPEED, 24'h000007));
    wr(8'h08, st(mps_pkg::OP_MOVABS, 24'h000064));
    start(3'h0);
    wt(0, 1'b1, 20);
    chk("sync strobe", syncStrobe, 1'b1);
    repeat (rng[20:18] + 2) @(negedge clk_sys);
    chk("output held", progOut1, 1'b0);
    @(posedge clk_sys) progIn1 <= 1'b1;
    wt(1, 1'b1, 10);
    chk("output set", progOut1, 1'b1);
    wt(1, 1'b0, 400);
    chk("dwell length", n >= dw * MSC, 1'b1);
    wt(3, 1'b0, 400);
    chk("program end", running, 1'b0);
    chk("home pulse", sawHome, 1'b1);
    chk("tally clear", clrCnt, 32'h00000001);
    chk("move speed", lastCmd.speed, 24'h000007);
    chk("move scurve", lastCmd.scurve, rng[7:0]);
    // output-set with a two millisecond on-time
    wr(mps_pkg::ADDR_ON_TIME, 32'h00000002);
    wr(8'h82, 32'h00000028);
    wr(8'h28, st(mps_pkg::OP_OUTSET, 24'h000001));
    start(3'h2);
    wt(1, 1'b1, 10);
    wt(1, 1'b0, 40);
    chk("on-time length", n >= 2 * MSC, 1'b1);
    chk("step held in on-time", running, 1'b1);
    wt(3, 1'b0, 10);
    chk("on-time program end", running, 1'b0);
    // three-pass loop, then a halt that has no travel left
    wr(8'h83, 32'h00000030);
    wr(8'h30, st(mps_pkg::OP_LOOPB, 24'h000003));
    wr(8'h31, st(mps_pkg::OP_TALLY, 24'h000000));
    wr(8'h32, st(mps_pkg::OP_LOOPE, 24'h000000));
    wr(8'h33, st(mps_pkg::OP_WAITIN, 24'h000001));
    wr(8'h34, st(mps_pkg::OP_HALT, 24'h000005));
    start(3'h3);
    wt(3, 1'b0, 40);
    chk("loop passes", clrCnt, 32'h00000004);
    chk("halt skipped", sawHalt, 1'b0);
    chk("halt after wait", progError, 1'b0);
    for (int i = 0; i < 3; i++) begin
      wr(8'h81, 32'h00000014);
      wr(8'h14, i == 0 ? st(mps_pkg::OP_OUTSET, 24'h2) :
                i == 1 ? st(mps_pkg::OP_WPREL, 24'h5) : st(mps_pkg::OP_HALT, 24'h5));
      start(3'h1);
      wt(2, 1'b1, 20);
      chk("program error", progError, 1'b1);
      rdr(mps_pkg::ADDR_STATUS);
      chk("status error bit", rd[mps_pkg::STAT_ERR_BIT], 1'b1);
    end
    conclude();
  end
  // watchdog: about ten thousand cycles
  initial begin
    #400us;
    errors++;
    conclude();
  end
endmodule : testbench
